/* rtl/iowdt_top.sv */
// i/o port watchdog timer top: single port, write arms/refreshes, read disarms
// assumes io strobes are single-cycle pulses synchronous to mclk
`timescale 1ns/10ps
module iowdt_top #(
    parameter int TICK_CYC = iowdt_pkg::IOWDT_TICK_CYC
) (
    input  wire logic               mclk,
    input  wire logic               rst,
    input  wire logic               ce,
    input  wire iowdt_pkg::iowdt_io_req_t io_req,
    output logic [7:0]              io_rdata,
    output logic                    armed,
    output logic                    sys_rst
);
    import iowdt_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        iowdt_state_t st;
        logic [5:0]   secs;
        logic [5:0]   code;
        logic [7:0]   rdata;
        logic [7:0]   rst_cnt;
        logic         sys_rst;
        logic         armed;
    } iowdt_st_t;

    iowdt_st_t s_q, s_d;
    logic      hit_wr;
    logic      hit_rd;
    logic      tick;
    logic      code_ok;

    // ----------------------------------------------------------------
    // port decode
    // ----------------------------------------------------------------
    assign hit_wr  = io_req.wr && io_req.addr == IOWDT_PORT_ADDR;
    assign hit_rd  = io_req.rd && io_req.addr == IOWDT_PORT_ADDR;
    // code 00 and any value with either top data bit set are ignored: out-of-range codes never arm
    assign code_ok = io_req.wdata[7:6] == 2'b00 && io_req.wdata[5:0] >= IOWDT_CODE_MIN;

    // ----------------------------------------------------------------
    // time base
    // ----------------------------------------------------------------
    // any port access restarts the seconds base, so an interval counts whole seconds from the access;
    // the price is that frequent refreshes keep shifting the tick phase
    iowdt_tick #(
        .TICK_CYC (TICK_CYC)
    ) u_tick (
        .mclk    (mclk),
        .rst     (rst),
        .ce      (ce),
        .restart (hit_wr || hit_rd),
        .tick    (tick)
    );

    // ----------------------------------------------------------------
    // countdown machine
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (hit_rd) begin
            s_d.rdata = IOWDT_RDATA_VAL;
        end
        case (s_q.st)
            IOWDT_IDLE: begin
                // a read in the same cycle wins, so software can always leave the watchdog disarmed
                if (hit_wr && code_ok && !hit_rd) begin
                    s_d.st   = IOWDT_ARMED;
                    s_d.code = io_req.wdata[5:0];
                    s_d.secs = io_req.wdata[5:0];
                end
            end
            IOWDT_ARMED: begin
                if (hit_rd) begin
                    s_d.st = IOWDT_IDLE;
                end else if (hit_wr && code_ok) begin
                    s_d.code = io_req.wdata[5:0];
                    s_d.secs = io_req.wdata[5:0];
                end else if (tick) begin
                    if (s_q.secs == 6'h01) begin
                        s_d.st      = IOWDT_FIRE;
                        s_d.secs    = IOWDT_CODE_RST;
                        s_d.rst_cnt = 8'(IOWDT_RST_CYC - 1);
                    end else begin
                        s_d.secs = s_q.secs - 6'h01;
                    end
                end
            end
            IOWDT_FIRE: begin
                // reset pulse runs to its end; the watchdog then stays disarmed
                if (s_q.rst_cnt == 8'h00) begin
                    s_d.st = IOWDT_IDLE;
                end else begin
                    s_d.rst_cnt = s_q.rst_cnt - 8'h01;
                end
            end
            default: begin
                s_d.st = IOWDT_IDLE;
            end
        endcase
        s_d.sys_rst = s_d.st == IOWDT_FIRE;
        s_d.armed   = s_d.st == IOWDT_ARMED;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q         <= '0;
            s_q.st      <= IOWDT_IDLE;
            s_q.code    <= IOWDT_CODE_RST;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign io_rdata = s_q.rdata;
    assign armed    = s_q.armed;
    assign sys_rst  = s_q.sys_rst;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_write_arms: assert property (@(posedge mclk) disable iff (rst)
        (ce && hit_wr && code_ok && !hit_rd && !sys_rst) |=> (armed && s_q.secs == $past(io_req.wdata[5:0])))
        else $error("valid write did not arm with its code");

    a_read_disarms: assert property (@(posedge mclk) disable iff (rst)
        (ce && hit_rd && s_q.st == IOWDT_ARMED) |=> !armed)
        else $error("read did not disarm");

    a_idle_stays: assert property (@(posedge mclk) disable iff (rst)
        (!armed && !sys_rst && !(hit_wr && code_ok)) |=> !armed)
        else $error("armed without a write");

    a_bad_code: assert property (@(posedge mclk) disable iff (rst)
        (ce && hit_wr && !code_ok && !armed && !sys_rst) |=> !armed)
        else $error("out of range code armed");

    a_refresh_reload: assert property (@(posedge mclk) disable iff (rst)
        (ce && armed && hit_wr && code_ok && !hit_rd) |=> (s_q.secs == $past(io_req.wdata[5:0])))
        else $error("refresh did not reload");

    a_expiry_reset: assert property (@(posedge mclk) disable iff (rst)
        (ce && armed && tick && s_q.secs == 6'h01 && !hit_wr && !hit_rd) |=> sys_rst)
        else $error("expiry did not assert reset");

    a_reset_cause: assert property (@(posedge mclk) disable iff (rst)
        $rose(sys_rst) |-> $past(armed))
        else $error("reset without armed countdown");

    a_count_step: assert property (@(posedge mclk) disable iff (rst)
        (ce && armed && tick && s_q.secs > 6'h01 && !hit_wr && !hit_rd) |=> s_q.secs == $past(s_q.secs) - 6'h01)
        else $error("countdown step wrong");

    a_no_tick_hold: assert property (@(posedge mclk) disable iff (rst)
        (ce && armed && !tick && !hit_wr && !hit_rd) |=> (armed && s_q.secs == $past(s_q.secs)))
        else $error("countdown moved without a tick");

    a_secs_nonzero: assert property (@(posedge mclk) disable iff (rst)
        armed |-> s_q.secs != 6'h00)
        else $error("armed with zero seconds left");

    a_secs_bound: assert property (@(posedge mclk) disable iff (rst)
        armed |-> s_q.secs <= s_q.code)
        else $error("remaining seconds above loaded code");

    a_bad_refresh: assert property (@(posedge mclk) disable iff (rst)
        (ce && armed && hit_wr && !code_ok && !hit_rd && !tick) |=> s_q.secs == $past(s_q.secs))
        else $error("out of range code reloaded the countdown");

    a_tick_restart: assert property (@(posedge mclk) disable iff (rst)
        (ce && (hit_wr || hit_rd)) |=> !tick)
        else $error("time base not restarted by port access");

    a_ce_freeze: assert property (@(posedge mclk) disable iff (rst)
        !ce |=> $stable(s_q))
        else $error("state moved while clock enable low");

    a_rw_read_wins: assert property (@(posedge mclk) disable iff (rst)
        (ce && hit_wr && hit_rd) |=> !armed)
        else $error("write beat read in the same cycle");

    a_read_data: assert property (@(posedge mclk) disable iff (rst)
        (ce && hit_rd) |=> io_rdata == IOWDT_RDATA_VAL)
        else $error("read data not the fixed value");

    // ----------------------------------------------------------------
    // checks: expiry and reset pulse
    // ----------------------------------------------------------------
    a_expiry_disarms: assert property (@(posedge mclk) disable iff (rst)
        (ce && armed && tick && s_q.secs == 6'h01 && !hit_wr && !hit_rd) |=> !armed)
        else $error("still armed after expiry");

    a_not_both: assert property (@(posedge mclk) disable iff (rst)
        armed |-> !sys_rst)
        else $error("armed during reset pulse");

    a_idle_no_fire: assert property (@(posedge mclk) disable iff (rst)
        (!armed && !sys_rst) |=> !sys_rst)
        else $error("reset pulse out of idle");

    a_fire_length: assert property (@(posedge mclk) disable iff (rst)
        $rose(sys_rst) |-> s_q.rst_cnt == 8'(IOWDT_RST_CYC - 1))
        else $error("reset pulse counter not loaded");

    a_fire_hold: assert property (@(posedge mclk) disable iff (rst)
        (ce && sys_rst && s_q.rst_cnt != 8'h00) |=> sys_rst)
        else $error("reset pulse cut short");

    a_fire_end: assert property (@(posedge mclk) disable iff (rst)
        (ce && sys_rst && s_q.rst_cnt == 8'h00) |=> (!sys_rst && !armed))
        else $error("reset pulse did not end disarmed");

    a_fire_ignores: assert property (@(posedge mclk) disable iff (rst)
        (ce && sys_rst && hit_wr) |=> !armed)
        else $error("write during reset pulse armed");
endmodule

/* rtl/iowdt_pkg.sv */
// package for the i/o port watchdog: port address, code limits, timing constants and carrier types
// assumes a 50 mhz mclk and an isa-style i/o strobe interface in the same clock domain
package iowdt_pkg;
    // ----------------------------------------------------------------
    // addresses and codes
    // ----------------------------------------------------------------
    localparam logic [15:0] IOWDT_PORT_ADDR  = 16'h0443;
    localparam logic [5:0]  IOWDT_CODE_MIN   = 6'h01;
    localparam logic [5:0]  IOWDT_CODE_MAX   = 6'h3F;
    localparam logic [5:0]  IOWDT_CODE_RST   = 6'h00;
    localparam logic [7:0]  IOWDT_RDATA_VAL  = 8'hFF;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int          IOWDT_CLK_HZ     = 50000000;
    localparam int          IOWDT_TICK_NS    = 1000000000;
    localparam int          IOWDT_CLK_NS     = 20;
    localparam int          IOWDT_TICK_CYC   = IOWDT_TICK_NS / IOWDT_CLK_NS;
    localparam int          IOWDT_RST_NS     = 1000;
    localparam int          IOWDT_RST_CYC    = (IOWDT_RST_NS + IOWDT_CLK_NS - 1) / IOWDT_CLK_NS;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } iowdt_io_req_t;

    typedef enum logic [2:0] {
        IOWDT_IDLE  = 3'b001,
        IOWDT_ARMED = 3'b010,
        IOWDT_FIRE  = 3'b100
    } iowdt_state_t;
endpackage

/* rtl/iowdt_tick.sv */
// one-second time base: a single-cycle pulse every tick_cyc cycles
// assumes the caller restarts it whenever a countdown is reloaded
`timescale 1ns/10ps
module iowdt_tick #(
    parameter int TICK_CYC = 50000000
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic restart,
    output logic      tick
);
    import iowdt_pkg::*;

    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } iowdt_tick_st_t;

    iowdt_tick_st_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (restart) begin
            s_d.cnt = 32'h0;
        end else if (s_q.cnt == 32'(TICK_CYC - 1)) begin
            s_d.cnt = 32'h0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 32'h1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

    a_tick_period: assert property (@(posedge mclk) disable iff (rst)
        (ce && !restart && s_q.cnt == 32'(TICK_CYC - 1)) |=> tick)
        else $error("counter wrap without tick pulse");
endmodule

/* verif/iowdt_top_tb.sv */
// self-checking bench for the i/o port watchdog top
// assumes the rtl package and top are compiled first; time base shortened to TICK cycles
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module iowdt_top_tb;
    import iowdt_pkg::*;
    localparam int TICK = 10;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  data;
        logic        exp_armed;
    } iowdt_row_t;
    logic          mclk = 1'b0;
    logic          rst  = 1'b1;
    logic          ce   = 1'b1;
    iowdt_io_req_t io_req = '0;
    logic [7:0]    io_rdata;
    logic          armed;
    logic          sys_rst;
    int            err_total = 0;
    int            num_checks = 0;
    int            c;
    logic [7:0]    exp_rd;
    iowdt_row_t    rows [10] = '{
        '{1'b1, 1'b0, 16'h0443, 8'h01, 1'b1}, '{1'b1, 1'b0, 16'h0443, 8'h3F, 1'b1},
        '{1'b0, 1'b1, 16'h0443, 8'h00, 1'b0}, '{1'b1, 1'b0, 16'h0443, 8'h00, 1'b0},
        '{1'b1, 1'b0, 16'h0443, 8'h40, 1'b0}, '{1'b1, 1'b0, 16'h0442, 8'h05, 1'b0},
        '{1'b1, 1'b0, 16'h0443, 8'h0A, 1'b1}, '{1'b0, 1'b1, 16'h0442, 8'h00, 1'b1},
        '{1'b1, 1'b1, 16'h0443, 8'h07, 1'b0}, '{1'b1, 1'b1, 16'h0443, 8'h07, 1'b0}};

    iowdt_top #(.TICK_CYC(TICK)) i_dut (
        .mclk     (mclk),
        .rst      (rst),
        .ce       (ce),
        .io_req   (io_req),
        .io_rdata (io_rdata),
        .armed    (armed),
        .sys_rst  (sys_rst)
    );

    always #10 mclk = ~mclk;

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    // one-cycle strobe; returns just after the taking edge has settled
    task automatic io(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk) io_req <= '{w, r, a, d};
        @(posedge mclk) io_req <= '0;
        #1;
    endtask

    // still armed just before n seconds, then reset pulse of the chosen length
    task automatic expire(input int n);
        repeat (n * TICK - 2) @(posedge mclk);
        #1;
        `CHK(armed, 1'b1)
        c = 0;
        while (sys_rst !== 1'b1 && c < 6) begin
            @(posedge mclk);
            #1;
            c++;
        end
        `CHK(sys_rst, 1'b1)
        `CHK(armed, 1'b0)
        c = 0;
        while (sys_rst === 1'b1 && c < 200) begin
            c++;
            @(posedge mclk);
            #1;
        end
        `CHK(c, IOWDT_RST_CYC)
    endtask

    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        #1;
        `CHK({armed, sys_rst, io_rdata}, 10'h000)
        exp_rd = 8'h00;
        foreach (rows[i]) begin
            io(rows[i].wr, rows[i].rd, rows[i].addr, rows[i].data);
            if (rows[i].rd && rows[i].addr == IOWDT_PORT_ADDR)
                exp_rd = IOWDT_RDATA_VAL;
            `CHK(armed, rows[i].exp_armed)
            `CHK(io_rdata, exp_rd)
        end
        io(1'b1, 1'b0, 16'h0443, 8'h01);
        expire(1);
        io(1'b1, 1'b0, 16'h0443, 8'h03);
        expire(3);
        // refresh part way through; the new code must govern, not the old remainder
        io(1'b1, 1'b0, 16'h0443, 8'h03);
        repeat (2 * TICK) @(posedge mclk);
        io(1'b1, 1'b0, 16'h0443, 8'h02);
        expire(2);
        // a write during the reset pulse must neither arm nor shorten the pulse
        io(1'b1, 1'b0, 16'h0443, 8'h01);
        repeat (TICK) @(posedge mclk);
        io(1'b1, 1'b0, 16'h0443, 8'h05);
        `CHK({armed, sys_rst}, 2'b01)
        c = 0;
        while (sys_rst === 1'b1 && c < 60) begin
            c++;
            @(posedge mclk);
            #1;
        end
        `CHK(c, IOWDT_RST_CYC - 1)
        `CHK(armed, 1'b0)
        io(1'b1, 1'b0, 16'h0443, 8'h01);
        @(posedge mclk) ce <= 1'b0;
        repeat (3 * TICK) @(posedge mclk);
        #1;
        `CHK({armed, sys_rst}, 2'b10)
        @(posedge mclk) ce <= 1'b1;
        io(1'b1, 1'b0, 16'h0443, 8'h3F);
        repeat (5) @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk) rst <= 1'b0;
        #1;
        `CHK({armed, sys_rst, io_rdata}, 10'h000)
        tally_and_finish();
    end

    // run is a few dozen ticks long; allow a wide margin
    initial begin
        #400000;
        err_total++;
        tally_and_finish();
    end
endmodule
